// [pkg/pbocr_pkg.sv]
// Register map, reset values, timing and serial-port states for the phase balance block.
package pbocr_pkg;

  // Register offsets on the two-wire port.
  localparam logic [7:0] PBOCR_ADDR_LOCK   = 8'h00;
  localparam logic [7:0] PBOCR_ADDR_GAIN   = 8'h1F;
  localparam logic [7:0] PBOCR_ADDR_OFFS   = 8'h20;
  localparam logic [7:0] PBOCR_ADDR_LOGAIN = 8'h21;
  localparam logic [7:0] PBOCR_ADDR_HIGAIN = 8'h22;
  localparam logic [7:0] PBOCR_ADDR_DLY    = 8'h23;
  localparam logic [7:0] PBOCR_ADDR_THR    = 8'h24;
  localparam logic [7:0] PBOCR_ADDR_STAT   = 8'h2A;

  // Writes to all but the lock register are refused while it holds this key.
  localparam logic [7:0] PBOCR_LOCK_KEY = 8'hA6;

  // Reset values.
  localparam logic [7:0] PBOCR_LOCK_RST   = 8'h00;
  localparam logic [4:0] PBOCR_GAIN_RST   = 5'h10;
  localparam logic [4:0] PBOCR_OFFS_RST   = 5'h00;
  localparam logic [7:0] PBOCR_LOGAIN_RST = 8'h00;
  localparam logic [7:0] PBOCR_HIGAIN_RST = 8'h00;
  localparam logic [1:0] PBOCR_DLY_RST    = 2'h1;
  localparam logic [5:0] PBOCR_THR_RST    = 6'h00;

  // Field positions.
  localparam int PBOCR_OFFS_SIGN_BIT = 4;
  localparam int PBOCR_THR_SIGN_BIT  = 5;
  localparam int PBOCR_STAT_SUMMED_OVERCURRENT_PROTECTION_BIT = 2;

  // Summed-current limit in millivolts: nominal and step per offset code.
  localparam logic [11:0] PBOCR_LIMIT_NOM_MV  = 12'h898;
  localparam logic [11:0] PBOCR_LIMIT_STEP_MV = 12'h032;

  // Longest qualification delay (code 00); each code step halves it.
  localparam int PBOCR_CLK_PERIOD_NS  = 20;
  localparam int PBOCR_SUMMED_OVERCURRENT_PROTECTION_DLY_MAX_NS = 112000;
  localparam int PBOCR_SUMMED_OVERCURRENT_PROTECTION_DLY_MAX_CYC = PBOCR_SUMMED_OVERCURRENT_PROTECTION_DLY_MAX_NS / PBOCR_CLK_PERIOD_NS;

  localparam logic [3:0] PBOCR_BYTE_BITS = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_ADDR  = 4'h1,
    ST_AACK  = 4'h2,
    ST_PTR   = 4'h3,
    ST_PACK  = 4'h4,
    ST_WDATA = 4'h5,
    ST_WACK  = 4'h6,
    ST_RDATA = 4'h7,
    ST_RACK  = 4'h8
  } pbocr_i2c_st_t;

endpackage : pbocr_pkg

// [rtl/pbocr_summed_overcurrent_protection_timer.sv]
// Qualification timer for the summed-overcurrent comparator.
`timescale 1ns/1ps
module pbocr_summed_overcurrent_protection_timer #(
  parameter int CNT_W = 13
) (
  // Clock and reset.
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // Comparator level and selected delay.
  input  wire logic             over,
  input  wire logic [CNT_W-1:0] dly_cyc,
  // Qualified event.
  output logic                  trip
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             trip;
  } pbocr_tmr_t;

  pbocr_tmr_t s_r;
  pbocr_tmr_t s_nxt;
  logic [CNT_W-1:0] last_cnt;

  assign last_cnt = CNT_W'(dly_cyc - 1'b1);

  always_comb begin
    s_nxt = s_r;
    if (!over) begin
      s_nxt.cnt  = '0; // R12
      s_nxt.trip = 1'b0;
    end else if (s_r.cnt >= last_cnt) begin
      s_nxt.trip = 1'b1; // R12
    end else begin
      s_nxt.cnt = CNT_W'(s_r.cnt + 1'b1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign trip = s_r.trip;

  sequence s_qualified;
    over && !s_r.trip && s_r.cnt == last_cnt;
  endsequence

  property p_trip_after_hold;
    @(posedge mclk) disable iff (!rst_n)
    s_qualified |=> s_r.trip;
  endproperty
  a_trip_after_hold: assert property (p_trip_after_hold) // R12
    else $error("Event not raised after the full delay.");

  property p_no_early_trip;
    @(posedge mclk) disable iff (!rst_n)
    $rose(s_r.trip) |-> $past(over) && $past(s_r.cnt) >= $past(last_cnt);
  endproperty
  a_no_early_trip: assert property (p_no_early_trip) // R12
    else $error("Event raised before the delay ran out.");

  property p_restart_on_drop;
    @(posedge mclk) disable iff (!rst_n)
    !over |=> s_r.cnt == '0 && !s_r.trip;
  endproperty
  a_restart_on_drop: assert property (p_restart_on_drop) // R12
    else $error("Count did not restart when the current fell.");

endmodule : pbocr_summed_overcurrent_protection_timer

// [rtl/pbocr_regs.sv]
// Configuration registers of the phase balance and overcurrent block behind a two-wire port.
//
// Operation
// [R1] Phase-eight balance gain, five bits, resets 16/16.
// [R2] Offset register bit four chooses offset sign.
// [R3] Offset low nibble sets magnitude, resets zero.
// [R4] Writes refused while lock register holds key.
// [R5] Phases one-four threshold gains, two bits each.
// [R6] Phases five-eight threshold gains, same encoding.
// [R7] Summed delay code picks 112/56/28/14 us.
// [R8] Threshold bit five chooses raise or lower.
// [R9] Limit is 2.2 V plus/minus code times 50 mV.
// [R10] Threshold offset resets to zero, nominal limit.
// [R11] Status bit two shows summed overcurrent event.
// [R12] Event only after current stays above for delay.
`timescale 1ns/1ps
module pbocr_regs
  import pbocr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR      = 7'h20,
  parameter int         SUMMED_OVERCURRENT_PROTECTION_DLY_CYC = pbocr_pkg::PBOCR_SUMMED_OVERCURRENT_PROTECTION_DLY_MAX_CYC
) (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Two-wire serial port.
  input  wire logic        scl,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  // Summed-current comparator level.
  input  wire logic        sum_current_above,
  // Phase-eight current balance.
  output logic [4:0]       phase8_gain,
  output logic             phase8_offset_negative,
  output logic [3:0]       phase8_offset_code,
  // Per-phase overcurrent threshold gains.
  output logic [7:0]       low_phases_ocp_gain,
  output logic [7:0]       high_phases_ocp_gain,
  // Summed overcurrent protection.
  output logic [1:0]       summed_overcurrent_delay_code,
  output logic [11:0]      summed_overcurrent_limit_mv,
  output logic             summed_overcurrent_event
);

  localparam int CNT_W = $clog2(SUMMED_OVERCURRENT_PROTECTION_DLY_CYC + 1);

  typedef struct packed {
    logic          scl_s1;
    logic          scl_s2;
    logic          scl_d;
    logic          sda_s1;
    logic          sda_s2;
    logic          sda_d;
    logic          ovr_s1;
    logic          ovr_s2;
    pbocr_i2c_st_t state;
    logic [3:0]    bit_cnt;
    logic [7:0]    shreg;
    logic [7:0]    ptr;
    logic          rw;
    logic          mack;
    logic          sda_o;
    logic          sda_oe_n;
    logic [7:0]    lock;
    logic [4:0]    gain;
    logic [4:0]    offs;
    logic [7:0]    logain;
    logic [7:0]    higain;
    logic [1:0]    dly;
    logic [5:0]    thr;
    logic [11:0]   limit;
    logic [CNT_W-1:0] dly_cyc;
  } pbocr_state_t;

  pbocr_state_t s_r;
  pbocr_state_t s_nxt;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_cond;
  logic         stop_cond;
  logic         wr_stb;
  logic [7:0]   rd_cur;
  logic [7:0]   rd_next;
  logic         summed_overcurrent_protection_trip;

  function automatic logic [7:0] read_mux(input logic [7:0] a, input pbocr_state_t s,
                                          input logic trip);
    logic [7:0] d;
    d = 8'h00;
    if (a == PBOCR_ADDR_LOCK) begin
      d = s.lock;
    end else if (a == PBOCR_ADDR_GAIN) begin
      d = {3'h0, s.gain};
    end else if (a == PBOCR_ADDR_OFFS) begin
      d = {3'h0, s.offs};
    end else if (a == PBOCR_ADDR_LOGAIN) begin
      d = s.logain;
    end else if (a == PBOCR_ADDR_HIGAIN) begin
      d = s.higain;
    end else if (a == PBOCR_ADDR_DLY) begin
      d = {6'h00, s.dly};
    end else if (a == PBOCR_ADDR_THR) begin
      d = {2'h0, s.thr};
    end else if (a == PBOCR_ADDR_STAT) begin
      d[PBOCR_STAT_SUMMED_OVERCURRENT_PROTECTION_BIT] = trip; // R11
    end
    return d;
  endfunction : read_mux

  function automatic logic [11:0] limit_of(input logic [5:0] t);
    logic [11:0] step;
    step = 12'(12'(t[4:0]) * PBOCR_LIMIT_STEP_MV);
    if (t[PBOCR_THR_SIGN_BIT]) begin
      return 12'(PBOCR_LIMIT_NOM_MV - step); // R8
    end
    return 12'(PBOCR_LIMIT_NOM_MV + step); // R9
  endfunction : limit_of

  // Edges are taken from the second synchroniser stage and its delayed copy.
  assign scl_rise   = s_r.scl_s2 & ~s_r.scl_d;
  assign scl_fall   = ~s_r.scl_s2 & s_r.scl_d;
  assign start_cond = s_r.scl_s2 & s_r.scl_d & s_r.sda_d & ~s_r.sda_s2;
  assign stop_cond  = s_r.scl_s2 & s_r.scl_d & ~s_r.sda_d & s_r.sda_s2;
  assign rd_cur     = read_mux(s_r.ptr, s_r, summed_overcurrent_protection_trip);
  assign rd_next    = read_mux(8'(s_r.ptr + 1'b1), s_r, summed_overcurrent_protection_trip);

  always_comb begin
    s_nxt        = s_r;
    wr_stb       = 1'b0;
    s_nxt.scl_s1 = scl;
    s_nxt.scl_s2 = s_r.scl_s1;
    s_nxt.scl_d  = s_r.scl_s2;
    s_nxt.sda_s1 = sda_in;
    s_nxt.sda_s2 = s_r.sda_s1;
    s_nxt.sda_d  = s_r.sda_s2;
    s_nxt.ovr_s1 = sum_current_above;
    s_nxt.ovr_s2 = s_r.ovr_s1;
    if (start_cond) begin
      s_nxt.state    = ST_ADDR;
      s_nxt.bit_cnt  = 4'h0;
      s_nxt.sda_oe_n = 1'b1;
    end else if (stop_cond) begin
      s_nxt.state    = ST_IDLE;
      s_nxt.sda_oe_n = 1'b1;
    end else if (scl_rise) begin
      case (s_r.state)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          s_nxt.shreg   = {s_r.shreg[6:0], s_r.sda_s2};
          s_nxt.bit_cnt = 4'(s_r.bit_cnt + 1'b1);
        end
        ST_RDATA: s_nxt.bit_cnt = 4'(s_r.bit_cnt + 1'b1);
        ST_RACK:  s_nxt.mack = ~s_r.sda_s2;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (s_r.state)
        ST_ADDR: begin
          if (s_r.bit_cnt == PBOCR_BYTE_BITS) begin
            if (s_r.shreg[7:1] == DEV_ADDR) begin
              s_nxt.state    = ST_AACK;
              s_nxt.rw       = s_r.shreg[0];
              s_nxt.sda_oe_n = 1'b0;
            end else begin
              s_nxt.state = ST_IDLE;
            end
          end
        end
        ST_PTR: begin
          if (s_r.bit_cnt == PBOCR_BYTE_BITS) begin
            s_nxt.ptr      = s_r.shreg;
            s_nxt.state    = ST_PACK;
            s_nxt.sda_oe_n = 1'b0;
          end
        end
        ST_WDATA: begin
          if (s_r.bit_cnt == PBOCR_BYTE_BITS) begin
            wr_stb         = 1'b1;
            s_nxt.state    = ST_WACK;
            s_nxt.sda_oe_n = 1'b0;
          end
        end
        ST_AACK: begin
          s_nxt.bit_cnt = 4'h0;
          if (s_r.rw) begin
            s_nxt.state    = ST_RDATA;
            s_nxt.shreg    = rd_cur;
            s_nxt.sda_oe_n = rd_cur[7];
          end else begin
            s_nxt.state    = ST_PTR;
            s_nxt.sda_oe_n = 1'b1;
          end
        end
        ST_PACK, ST_WACK: begin
          s_nxt.bit_cnt  = 4'h0;
          s_nxt.state    = ST_WDATA;
          s_nxt.sda_oe_n = 1'b1;
          if (s_r.state == ST_WACK) begin
            s_nxt.ptr = 8'(s_r.ptr + 1'b1);
          end
        end
        ST_RDATA: begin
          if (s_r.bit_cnt == PBOCR_BYTE_BITS) begin
            s_nxt.state    = ST_RACK;
            s_nxt.sda_oe_n = 1'b1;
          end else begin
            s_nxt.shreg    = {s_r.shreg[6:0], 1'b0};
            s_nxt.sda_oe_n = s_r.shreg[6];
          end
        end
        ST_RACK: begin
          if (s_r.mack) begin
            s_nxt.ptr      = 8'(s_r.ptr + 1'b1);
            s_nxt.shreg    = rd_next;
            s_nxt.sda_oe_n = rd_next[7];
            s_nxt.bit_cnt  = 4'h0;
            s_nxt.state    = ST_RDATA;
          end else begin
            s_nxt.state = ST_IDLE;
          end
        end
        default: ;
      endcase
    end
    // The lock register itself stays writable so the key can be cleared.
    if (wr_stb) begin
      if (s_r.ptr == PBOCR_ADDR_LOCK) begin
        s_nxt.lock = s_r.shreg;
      end else if (s_r.lock != PBOCR_LOCK_KEY) begin // R4
        if (s_r.ptr == PBOCR_ADDR_GAIN) begin
          s_nxt.gain = s_r.shreg[4:0]; // R1
        end else if (s_r.ptr == PBOCR_ADDR_OFFS) begin
          s_nxt.offs = s_r.shreg[4:0]; // R2 R3
        end else if (s_r.ptr == PBOCR_ADDR_LOGAIN) begin
          s_nxt.logain = s_r.shreg; // R5
        end else if (s_r.ptr == PBOCR_ADDR_HIGAIN) begin
          s_nxt.higain = s_r.shreg; // R6
        end else if (s_r.ptr == PBOCR_ADDR_DLY) begin
          s_nxt.dly = s_r.shreg[1:0]; // R7
        end else if (s_r.ptr == PBOCR_ADDR_THR) begin
          s_nxt.thr = s_r.shreg[5:0]; // R8
        end
      end
    end
    s_nxt.limit   = limit_of(s_r.thr); // R9
    s_nxt.dly_cyc = CNT_W'(SUMMED_OVERCURRENT_PROTECTION_DLY_CYC >> s_r.dly); // R7
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_r          <= '0;
      s_r.scl_s1   <= 1'b1;
      s_r.scl_s2   <= 1'b1;
      s_r.scl_d    <= 1'b1;
      s_r.sda_s1   <= 1'b1;
      s_r.sda_s2   <= 1'b1;
      s_r.sda_d    <= 1'b1;
      s_r.state    <= ST_IDLE;
      s_r.sda_oe_n <= 1'b1;
      s_r.lock     <= PBOCR_LOCK_RST;
      s_r.gain     <= PBOCR_GAIN_RST; // R1
      s_r.offs     <= PBOCR_OFFS_RST; // R2 R3
      s_r.logain   <= PBOCR_LOGAIN_RST;
      s_r.higain   <= PBOCR_HIGAIN_RST;
      s_r.dly      <= PBOCR_DLY_RST; // R7
      s_r.thr      <= PBOCR_THR_RST; // R10
      s_r.limit    <= PBOCR_LIMIT_NOM_MV; // R10
      s_r.dly_cyc  <= CNT_W'(SUMMED_OVERCURRENT_PROTECTION_DLY_CYC >> PBOCR_DLY_RST);
    end else begin
      s_r <= s_nxt;
    end
  end

  pbocr_summed_overcurrent_protection_timer #(
    .CNT_W (CNT_W)
  ) u_summed_overcurrent_protection_timer (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .over    (s_r.ovr_s2),
    .dly_cyc (s_r.dly_cyc),
    .trip    (summed_overcurrent_protection_trip)
  );

  assign sda_out                       = s_r.sda_o;
  assign sda_oe_n                      = s_r.sda_oe_n;
  assign phase8_gain                   = s_r.gain;
  assign phase8_offset_negative        = s_r.offs[PBOCR_OFFS_SIGN_BIT];
  assign phase8_offset_code            = s_r.offs[3:0];
  assign low_phases_ocp_gain           = s_r.logain;
  assign high_phases_ocp_gain          = s_r.higain;
  assign summed_overcurrent_delay_code = s_r.dly;
  assign summed_overcurrent_limit_mv   = s_r.limit;
  assign summed_overcurrent_event      = summed_overcurrent_protection_trip;

  sequence s_locked_write;
    wr_stb && s_r.ptr != PBOCR_ADDR_LOCK && s_r.lock == PBOCR_LOCK_KEY;
  endsequence

  sequence s_open_write(logic [7:0] a);
    wr_stb && s_r.ptr == a && s_r.lock != PBOCR_LOCK_KEY;
  endsequence

  property p_lock_blocks;
    @(posedge mclk) disable iff (!rst_n)
    s_locked_write |=> $stable({s_r.gain, s_r.offs, s_r.logain, s_r.higain, s_r.dly, s_r.thr});
  endproperty
  a_lock_blocks: assert property (p_lock_blocks) // R4
    else $error("Configuration changed while locked.");

  property p_reset_values;
    @(posedge mclk)
    !rst_n |=> s_r.gain == PBOCR_GAIN_RST && s_r.dly == PBOCR_DLY_RST && s_r.offs == '0;
  endproperty
  a_reset_values: assert property (p_reset_values) // R1
    else $error("Wrong reset value of gain, delay or offset.");

  property p_gain_write;
    @(posedge mclk) disable iff (!rst_n)
    s_open_write(PBOCR_ADDR_GAIN) |=> phase8_gain == $past(s_r.shreg[4:0]);
  endproperty
  a_gain_write: assert property (p_gain_write) // R1
    else $error("Balance gain write lost.");

  property p_offs_write;
    @(posedge mclk) disable iff (!rst_n)
    s_open_write(PBOCR_ADDR_OFFS) |=> phase8_offset_negative == $past(s_r.shreg[4])
      && phase8_offset_code == $past(s_r.shreg[3:0]);
  endproperty
  a_offs_write: assert property (p_offs_write) // R3
    else $error("Balance offset sign or code wrong after write.");

  property p_phase_gains;
    @(posedge mclk) disable iff (!rst_n)
    s_open_write(PBOCR_ADDR_HIGAIN) |=> high_phases_ocp_gain == $past(s_r.shreg)
      && $stable(low_phases_ocp_gain);
  endproperty
  a_phase_gains: assert property (p_phase_gains) // R6
    else $error("High phase gains wrong or low gains disturbed.");

  // The limit register trails the threshold register by one cycle, so it is held against the
  // code of the previous cycle; this also covers the cycle in which a write lands.
  property p_limit_raise;
    @(posedge mclk) disable iff (!rst_n)
    !s_r.thr[PBOCR_THR_SIGN_BIT] |=>
      summed_overcurrent_limit_mv
        == 12'(PBOCR_LIMIT_NOM_MV + 12'($past(s_r.thr[4:0])) * PBOCR_LIMIT_STEP_MV);
  endproperty
  a_limit_raise: assert property (p_limit_raise) // R9
    else $error("Raised limit does not match offset code.");

  property p_limit_lower;
    @(posedge mclk) disable iff (!rst_n)
    s_r.thr[PBOCR_THR_SIGN_BIT] |=>
      summed_overcurrent_limit_mv
        == 12'(PBOCR_LIMIT_NOM_MV - 12'($past(s_r.thr[4:0])) * PBOCR_LIMIT_STEP_MV);
  endproperty
  a_limit_lower: assert property (p_limit_lower) // R8
    else $error("Lowered limit does not match offset code.");

  property p_status_bit;
    @(posedge mclk) disable iff (!rst_n)
    s_r.ptr == PBOCR_ADDR_STAT |-> rd_cur == {5'h00, summed_overcurrent_protection_trip, 2'h0};
  endproperty
  a_status_bit: assert property (p_status_bit) // R11
    else $error("Status register does not reflect the event.");

  property p_delay_halves;
    @(posedge mclk) disable iff (!rst_n)
    s_r.dly == 2'h3 ##1 s_r.dly == 2'h3 |-> s_r.dly_cyc == CNT_W'(SUMMED_OVERCURRENT_PROTECTION_DLY_CYC / 8);
  endproperty
  a_delay_halves: assert property (p_delay_halves) // R7
    else $error("Shortest delay count wrong.");

endmodule : pbocr_regs

// [test/pbocr_i2c_host.sv]
// Two-wire host model that programs and reads the configuration registers.
`timescale 1ns/1ps
module pbocr_i2c_host #(
  parameter logic [6:0] DEV_ADDR = 7'h20,
  parameter int         HALF     = 5
) (
  // Clock.
  input  wire logic mclk,
  // Serial port pins of the device.
  output logic      scl,
  output logic      sda_in,
  input  wire logic sda_oe_n
);
  logic host_low_r;

  // The line has a pull-up, so it is high unless some party pulls it low.
  assign sda_in = ~(host_low_r | ~sda_oe_n);

  initial begin
    scl        = 1'b1;
    host_low_r = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  task automatic put_bit(input logic b);
    host_low_r <= ~b;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    scl <= 1'b0;
    tick(2);
  endtask : put_bit

  task automatic get_bit(output logic b);
    host_low_r <= 1'b0;
    tick(HALF);
    scl <= 1'b1;
    tick(3);
    b = sda_in;
    tick(HALF - 3);
    scl <= 1'b0;
    tick(2);
  endtask : get_bit

  task automatic start_cond();
    host_low_r <= 1'b0;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    host_low_r <= 1'b1;
    tick(HALF);
    scl <= 1'b0;
    tick(2);
  endtask : start_cond

  task automatic stop_cond();
    host_low_r <= 1'b1;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    host_low_r <= 1'b0;
    tick(HALF);
  endtask : stop_cond

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(b);
    ack = ~b;
  endtask : send_byte

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                           input logic [7:0] d, output logic ack);
    logic a0;
    logic a1;
    logic a2;
    start_cond();
    send_byte({dev, 1'b0}, a0);
    send_byte(ptr, a1);
    send_byte(d, a2);
    stop_cond();
    ack = a0 & a1 & a2;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d);
    logic a;
    start_cond();
    send_byte({DEV_ADDR, 1'b0}, a);
    send_byte(ptr, a);
    start_cond();
    send_byte({DEV_ADDR, 1'b1}, a);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(1'b1);
    stop_cond();
  endtask : read_reg
endmodule : pbocr_i2c_host

// [test/pbocr_regs_test.sv]
// Self-checking bench for the phase balance and overcurrent registers.
`timescale 1ns/1ps
module pbocr_regs_test;
  import pbocr_pkg::*;
  localparam int DLY   = 64;
  localparam int LIMIT = 40000;
  localparam logic [7:0] ADR [7] = '{8'h00, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24};
  localparam logic [7:0] RST [7] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
  localparam logic [7:0] THR [4] = '{8'h05, 8'h25, 8'h3F, 8'h1F};

  logic        mclk;
  logic        rst_n;
  logic        scl;
  logic        sda_in;
  logic        sda_out;
  logic        sda_oe_n;
  logic        above;
  logic [4:0]  phase8_gain;
  logic        phase8_offset_negative;
  logic [3:0]  phase8_offset_code;
  logic [7:0]  low_phases_ocp_gain;
  logic [7:0]  high_phases_ocp_gain;
  logic [1:0]  summed_overcurrent_delay_code;
  logic [11:0] summed_overcurrent_limit_mv;
  logic        summed_overcurrent_event;
  int          err_count;
  int          n_compared;
  int          cycles;
  int          n;
  int          w;

  pbocr_regs #(.DEV_ADDR(7'h20), .SUMMED_OVERCURRENT_PROTECTION_DLY_CYC(DLY)) u_pbocr_regs (
    .mclk(mclk), .rst_n(rst_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .sum_current_above(above), .phase8_gain(phase8_gain),
    .phase8_offset_negative(phase8_offset_negative),
    .phase8_offset_code(phase8_offset_code), .low_phases_ocp_gain(low_phases_ocp_gain),
    .high_phases_ocp_gain(high_phases_ocp_gain),
    .summed_overcurrent_delay_code(summed_overcurrent_delay_code),
    .summed_overcurrent_limit_mv(summed_overcurrent_limit_mv),
    .summed_overcurrent_event(summed_overcurrent_event));

  pbocr_i2c_host #(.DEV_ADDR(7'h20)) u_pbocr_i2c_host (
    .mclk(mclk), .scl(scl), .sda_in(sda_in), .sda_oe_n(sda_oe_n));

  initial mclk = 1'b0;
  always #10 mclk = ~mclk;

  task automatic stop_test();
    $display("compared %0d, mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_count++;
      $display("run exceeded its cycle limit");
      stop_test();
    end
  end

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    logic ack;
    u_pbocr_i2c_host.write_reg(7'h20, ptr, d, ack);
    chk("write acknowledge", 12'h001, 12'(ack));
  endtask : wr

  task automatic rd_chk(input logic [7:0] ptr, input logic [7:0] exp);
    logic [7:0] d;
    u_pbocr_i2c_host.read_reg(ptr, d);
    chk($sformatf("read of %h", ptr), 12'(exp), 12'(d));
  endtask : rd_chk

  function automatic logic [11:0] lim(input logic [7:0] d);
    return d[5] ? 12'h898 - 12'(d[4:0]) * 12'h032 : 12'h898 + 12'(d[4:0]) * 12'h032;
  endfunction : lim

  initial begin
    logic ack;
    rst_n      = 1'b0;
    above      = 1'b0;
    err_count  = 0;
    n_compared = 0;
    cycles     = 0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (5) @(posedge mclk);
    chk("gain", 12'h010, 12'(phase8_gain));
    chk("offset sign", 12'h000, 12'(phase8_offset_negative));
    chk("offset code", 12'h000, 12'(phase8_offset_code));
    chk("low gains", 12'h000, 12'(low_phases_ocp_gain));
    chk("high gains", 12'h000, 12'(high_phases_ocp_gain));
    chk("delay code", 12'h001, 12'(summed_overcurrent_delay_code));
    chk("limit", 12'h898, summed_overcurrent_limit_mv);
    chk("event", 12'h000, 12'(summed_overcurrent_event));
    chk("sda out", 12'h000, 12'(sda_out));
    for (int i = 0; i < 7; i++) begin
      rd_chk(ADR[i], RST[i]);
    end
    $display("test reset values done");

    wr(PBOCR_ADDR_GAIN, 8'h1F);
    chk("gain max", 12'h01F, 12'(phase8_gain));
    wr(PBOCR_ADDR_GAIN, 8'h00);
    chk("gain min", 12'h000, 12'(phase8_gain));
    wr(PBOCR_ADDR_OFFS, 8'h1F);
    chk("offset sign", 12'h001, 12'(phase8_offset_negative));
    chk("offset code", 12'h00F, 12'(phase8_offset_code));
    wr(PBOCR_ADDR_OFFS, 8'h0E);
    chk("offset sign", 12'h000, 12'(phase8_offset_negative));
    chk("offset code", 12'h00E, 12'(phase8_offset_code));
    wr(PBOCR_ADDR_LOGAIN, 8'hE4);
    chk("low gains", 12'h0E4, 12'(low_phases_ocp_gain));
    wr(PBOCR_ADDR_HIGAIN, 8'h1B);
    chk("high gains", 12'h01B, 12'(high_phases_ocp_gain));
    rd_chk(PBOCR_ADDR_OFFS, 8'h0E);
    rd_chk(PBOCR_ADDR_HIGAIN, 8'h1B);
    for (int i = 0; i < 4; i++) begin
      wr(PBOCR_ADDR_THR, THR[i]);
      chk("limit", lim(THR[i]), summed_overcurrent_limit_mv);
    end
    $display("test field writes done");

    wr(PBOCR_ADDR_LOCK, PBOCR_LOCK_KEY);
    wr(PBOCR_ADDR_GAIN, 8'h05);
    chk("locked gain", 12'h000, 12'(phase8_gain));
    wr(PBOCR_ADDR_THR, 8'h01);
    chk("locked limit", lim(8'h1F), summed_overcurrent_limit_mv);
    rd_chk(PBOCR_ADDR_LOCK, PBOCR_LOCK_KEY);
    rd_chk(PBOCR_ADDR_GAIN, 8'h00);
    // The host clears the key before programming again.
    wr(PBOCR_ADDR_LOCK, 8'h00);
    wr(PBOCR_ADDR_GAIN, 8'h05);
    chk("unlocked gain", 12'h005, 12'(phase8_gain));
    $display("test write lock done");

    u_pbocr_i2c_host.write_reg(7'h21, PBOCR_ADDR_GAIN, 8'h09, ack);
    chk("foreign address ack", 12'h000, 12'(ack));
    chk("foreign address gain", 12'h005, 12'(phase8_gain));
    rd_chk(8'h30, 8'h00);
    wr(PBOCR_ADDR_STAT, 8'hFF);
    rd_chk(PBOCR_ADDR_STAT, 8'h00);
    $display("test refused accesses done");

    for (int c = 0; c < 4; c++) begin
      wr(PBOCR_ADDR_DLY, 8'(c));
      chk("delay code", 12'(c), 12'(summed_overcurrent_delay_code));
      n = DLY >> c;
      @(posedge mclk);
      above <= 1'b1;
      repeat (n / 2) @(posedge mclk);
      above <= 1'b0;
      @(posedge mclk);
      above <= 1'b1;
      // Two synchroniser cycles plus the full count: the event may not show one cycle earlier.
      repeat (n + 1) @(posedge mclk);
      #1;
      chk("event before delay", 12'h000, 12'(summed_overcurrent_event));
      w = 0;
      while (summed_overcurrent_event !== 1'b1 && w < 8) begin
        @(posedge mclk);
        #1;
        w++;
      end
      chk("event after delay", 12'h001, 12'(summed_overcurrent_event));
      rd_chk(PBOCR_ADDR_STAT, 8'h04);
      @(posedge mclk);
      above <= 1'b0;
      repeat (6) @(posedge mclk);
      #1;
      chk("event after drop", 12'h000, 12'(summed_overcurrent_event));
      rd_chk(PBOCR_ADDR_STAT, 8'h00);
    end
    $display("test summed overcurrent timing done");
    stop_test();
  end
endmodule : pbocr_regs_test
